// [timer_set_map.svh]
// register offsets, field positions and counts of the timer set
`ifndef TIMER_SET_MAP_SVH
`define TIMER_SET_MAP_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TS_STRIDE 8'h10
`define TS_CTRL_OFF 8'h00
`define TS_PERIOD_OFF 8'h04
`define TS_COUNT_OFF 8'h08
`define TS_IRQ_STATUS 8'h50
`define TS_IRQ_MASK 8'h54
`define TS_ADDR_W 8

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define TS_ON_BIT 15
`define TS_IDLE_BIT 13
`define TS_GATE_BIT 6
`define TS_PS_HI 5
`define TS_PS_LO 4
`define TS_WIDE_BIT 3
`define TS_SYNC_BIT 2
`define TS_CS_BIT 1
`define TS_MASK_FIRST 16'hA076
`define TS_MASK_LOW 16'hA07A
`define TS_MASK_HIGH 16'hA072
`define TS_CTRL_RST 16'h0000
`define TS_PERIOD_RST 16'hFFFF

// ----------------------------------------------------------------
// prescaler terminal counts and number of timers
// ----------------------------------------------------------------
`define TS_PS_LIM_1 8'h00
`define TS_PS_LIM_8 8'h07
`define TS_PS_LIM_64 8'h3F
`define TS_PS_LIM_256 8'hFF
`define TS_NUM_TIMERS 5

`endif

// [timer_set_pkg.sv]
// types shared by the timer set
package timer_set_pkg;
    typedef logic [15:0] word_type;
    typedef logic [1:0] prescale_type;
    typedef enum logic [1:0] {
        PS_DIV1 = 2'b00,
        PS_DIV8 = 2'b01,
        PS_DIV64 = 2'b10,
        PS_DIV256 = 2'b11
    } prescale_code_type;
endpackage

// [timer_slice.sv]
// one 16-bit timer: prescaler, counter and period compare
`include "timer_set_map.svh"
module timer_slice
    import timer_set_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic refClk,
    input wire logic sysRst,
    input wire logic tick,
    input wire logic [1:0] prescaleSel,
    input wire logic presClr,
    input wire logic useExtStep,
    input wire logic extStep,
    input wire logic useExtClr,
    input wire logic extClr,
    input wire logic [W-1:0] period,
    input wire logic countWr,
    input wire logic [W-1:0] countWdata,
    output logic [W-1:0] count,
    output logic step,
    output logic carry,
    output logic matchStep
);
    logic [7:0] presCnt_r;
    logic [7:0] presLim;
    logic presTick;
    logic clearNow;

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    always_comb begin
        case (prescale_code_type'(prescaleSel))
            PS_DIV8: presLim = `TS_PS_LIM_8;
            PS_DIV64: presLim = `TS_PS_LIM_64;
            PS_DIV256: presLim = `TS_PS_LIM_256;
            default: presLim = `TS_PS_LIM_1;
        endcase
    end

    assign presTick = tick && (presCnt_r == presLim);

    always_ff @(posedge refClk) begin
        if (sysRst || presClr) begin
            presCnt_r <= 8'h00;
        end else if (presTick) begin
            presCnt_r <= 8'h00;
        end else if (tick) begin
            presCnt_r <= presCnt_r + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // counter; holds when no step arrives
    // ----------------------------------------------------------------
    assign step = useExtStep ? extStep : presTick;
    assign clearNow = useExtClr ? extClr : (count == period);
    assign matchStep = step && clearNow;
    assign carry = step && (count == {W{1'b1}});

    always_ff @(posedge refClk) begin
        if (sysRst) begin
            count <= '0;
        end else if (countWr) begin
            count <= countWdata;
        end else if (step) begin
            count <= clearNow ? '0 : count + W'(1);
        end
    end
endmodule

// [timer_set.sv]
// five general-purpose timers: one standalone, two pairs joinable to 32 bits
//
// How it works
// - first timer: 16-bit, timer/sync/async counter modes
// - timer_on set starts, cleared stops each timer
// - idle_stop halts timer during device idle
// - gate_accum_en counts only while gate high, internal
// - prescale_sel divides by 1, 8, 64, 256
// - ext_clk_sync_sel synchronises external clock; internal ignores
// - clk_source_sel picks pin edges or oscillator/2
// - control write while running clears prescaler
// - first timer interrupts on match, gate fall
// - pair_wide_mode joins pair into one 32-bit
// - paired timers count synchronously only, never async
// - wide mode uses only lower control and pins
// - wide match raises upper timer's interrupt flag
// - upper period word high, lower period low
// - upper count holds high word, lower low
// - adc trigger from first pair only
`include "timer_set_map.svh"
module timer_set
    import timer_set_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idleMode,
    input wire logic first_timer_ext_clock_pin,
    input wire logic [3:0] pair_timer_ext_clock_pin,
    output logic irq,
    output logic adcTrigger
);
    localparam int N = `TS_NUM_TIMERS;

    word_type ctrl_r [N];
    word_type period_r [N];
    word_type count [N];
    logic [N-1:0] irqStatus_r;
    logic [N-1:0] irqMask_r;
    logic [N-1:0] pinMeta_r;
    logic [N-1:0] pinSync_r;
    logic [N-1:0] pinLast_r;
    logic [N-1:0] pinRise;
    logic [N-1:0] pinFall;
    logic [N-1:0] extPend_r;
    logic [N-1:0] tick;
    logic [N-1:0] presClr;
    logic [N-1:0] step;
    logic [N-1:0] carry;
    logic [N-1:0] matchStep;
    logic [N-1:0] useExtStep;
    logic [N-1:0] extStep;
    logic [N-1:0] useExtClr;
    logic [N-1:0] extClr;
    logic [N-1:0] countWr;
    logic [N-1:0] gateFall;
    logic [N-1:0] event_;
    logic [N-1:0] ctrlWr;
    logic [N-1:0] periodWr;
    logic [1:0] wide;
    logic [1:0] match32;
    logic intDiv_r;
    logic intTick;
    logic wrAccess;
    logic rdSetup;
    logic [3:0] slot;
    logic [3:0] sub;
    logic slotOk;
    logic regHit;
    logic [31:0] rdData;
    logic adcNxt;

    // ----------------------------------------------------------------
    // apb slave: zero wait, read data caught in the setup cycle
    // ----------------------------------------------------------------
    assign wrAccess = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;
    assign slot = paddr[7:4];
    assign sub = paddr[3:0];
    assign slotOk = (slot < 4'(N));
    assign pready = psel && penable;

    always_comb begin
        regHit = 1'b1;
        rdData = 32'h0000_0000;
        if (paddr == `TS_IRQ_STATUS) begin
            rdData = {27'h000_0000, irqStatus_r};
        end else if (paddr == `TS_IRQ_MASK) begin
            rdData = {27'h000_0000, irqMask_r};
        end else if (slotOk && sub == 4'(`TS_CTRL_OFF)) begin
            rdData = {16'h0000, ctrl_r[slot[2:0]]};
        end else if (slotOk && sub == 4'(`TS_PERIOD_OFF)) begin
            rdData = {16'h0000, period_r[slot[2:0]]};
        end else if (slotOk && sub == 4'(`TS_COUNT_OFF)) begin
            rdData = {16'h0000, count[slot[2:0]]};
        end else begin
            regHit = 1'b0;
        end
    end

    assign pslverr = pready && !regHit;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (rdSetup) begin
            prdata <= rdData;
        end
    end

    // ----------------------------------------------------------------
    // write strobes per timer
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N; i++) begin
            ctrlWr[i] = wrAccess && slot == 4'(i) && sub == 4'(`TS_CTRL_OFF);
            periodWr[i] = wrAccess && slot == 4'(i) && sub == 4'(`TS_PERIOD_OFF);
            countWr[i] = wrAccess && slot == 4'(i) && sub == 4'(`TS_COUNT_OFF);
        end
    end

    // ----------------------------------------------------------------
    // control and period registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < N; i++) begin
                ctrl_r[i] <= `TS_CTRL_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (ctrlWr[i]) begin
                    if (i == 0) begin
                        ctrl_r[i] <= pwdata[15:0] & `TS_MASK_FIRST;
                    end else if (i % 2 == 1) begin
                        ctrl_r[i] <= pwdata[15:0] & `TS_MASK_LOW;
                    end else begin
                        ctrl_r[i] <= pwdata[15:0] & `TS_MASK_HIGH;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < N; i++) begin
                period_r[i] <= `TS_PERIOD_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (periodWr[i]) begin
                    period_r[i] <= pwdata[15:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // internal clock: oscillator over two
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            intDiv_r <= 1'b0;
        end else begin
            intDiv_r <= !intDiv_r;
        end
    end

    assign intTick = intDiv_r;

    // ----------------------------------------------------------------
    // clock pin synchronisers and edge detect
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
            pinLast_r <= '0;
        end else begin
            pinMeta_r <= {pair_timer_ext_clock_pin, first_timer_ext_clock_pin};
            pinSync_r <= pinMeta_r;
            pinLast_r <= pinSync_r;
        end
    end

    assign pinRise = pinSync_r & ~pinLast_r;
    assign pinFall = ~pinSync_r & pinLast_r;
    assign wide[0] = ctrl_r[1][`TS_WIDE_BIT];
    assign wide[1] = ctrl_r[3][`TS_WIDE_BIT];

    // ----------------------------------------------------------------
    // per-timer clock source, gating and run control
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N; i++) begin
            logic running;
            logic syncMode;
            running = ctrl_r[i][`TS_ON_BIT]
                && !(idleMode && ctrl_r[i][`TS_IDLE_BIT]);
            syncMode = (i != 0) || ctrl_r[i][`TS_SYNC_BIT];
            tick[i] = 1'b0;
            gateFall[i] = 1'b0;
            if (running) begin
                if (ctrl_r[i][`TS_CS_BIT]) begin
                    tick[i] = syncMode ? (extPend_r[i] && intTick) : pinRise[i];
                end else if (ctrl_r[i][`TS_GATE_BIT]) begin
                    tick[i] = intTick && pinSync_r[i];
                    gateFall[i] = pinFall[i];
                end else begin
                    tick[i] = intTick;
                end
            end
            presClr[i] = ctrlWr[i] && ctrl_r[i][`TS_ON_BIT];
        end
    end

    // external edge held until the next internal tick in sync mode
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            extPend_r <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (pinRise[i]) begin
                    extPend_r[i] <= 1'b1;
                end else if (intTick) begin
                    extPend_r[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // pair cascade: low word steps, carry and 32-bit match into high
    // ----------------------------------------------------------------
    always_comb begin
        useExtStep = '0;
        extStep = '0;
        useExtClr = '0;
        extClr = '0;
        for (int p = 0; p < 2; p++) begin
            match32[p] = ({count[2*p+2], count[2*p+1]}
                == {period_r[2*p+2], period_r[2*p+1]});
            if (wide[p]) begin
                useExtClr[2*p+1] = 1'b1;
                extClr[2*p+1] = match32[p];
                useExtStep[2*p+2] = 1'b1;
                extStep[2*p+2] = carry[2*p+1] || (step[2*p+1] && match32[p]);
                useExtClr[2*p+2] = 1'b1;
                extClr[2*p+2] = match32[p];
            end
        end
    end

    generate
        for (genvar g = 0; g < N; g++) begin : gTimer
            timer_slice #(
                .W(16)
            ) uSlice (
                .refClk(ref_clk),
                .sysRst(sys_rst),
                .tick(tick[g]),
                .prescaleSel(ctrl_r[g][`TS_PS_HI:`TS_PS_LO]),
                .presClr(presClr[g]),
                .useExtStep(useExtStep[g]),
                .extStep(extStep[g]),
                .useExtClr(useExtClr[g]),
                .extClr(extClr[g]),
                .period(period_r[g]),
                .countWr(countWr[g]),
                .countWdata(pwdata[15:0]),
                .count(count[g]),
                .step(step[g]),
                .carry(carry[g]),
                .matchStep(matchStep[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt events, sticky status, mask
    // ----------------------------------------------------------------
    always_comb begin
        event_[0] = matchStep[0] || gateFall[0];
        for (int p = 0; p < 2; p++) begin
            if (wide[p]) begin
                event_[2*p+1] = 1'b0;
                event_[2*p+2] = matchStep[2*p+1] || gateFall[2*p+1];
            end else begin
                event_[2*p+1] = matchStep[2*p+1] || gateFall[2*p+1];
                event_[2*p+2] = matchStep[2*p+2] || gateFall[2*p+2];
            end
        end
    end

    // a set arriving with its clear wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irqStatus_r <= '0;
        end else if (wrAccess && paddr == `TS_IRQ_STATUS) begin
            irqStatus_r <= (irqStatus_r & ~pwdata[N-1:0]) | event_;
        end else begin
            irqStatus_r <= irqStatus_r | event_;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irqMask_r <= '0;
        end else if (wrAccess && paddr == `TS_IRQ_MASK) begin
            irqMask_r <= pwdata[N-1:0];
        end
    end

    assign irq = |(irqStatus_r & irqMask_r);

    // ----------------------------------------------------------------
    // adc trigger, first pair only
    // ----------------------------------------------------------------
    assign adcNxt = wide[0] ? matchStep[1] : matchStep[2];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            adcTrigger <= 1'b0;
        end else begin
            adcTrigger <= adcNxt;
        end
    end
endmodule

// [timer_set_props.sv]
// assertion checker of the timer set ports
module timer_set_props (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic adcTrigger
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic mapped;
    logic ctlAddr;
    logic [15:0] ctlMask;
    assign mapped = (paddr == 8'h50) || (paddr == 8'h54)
        || (paddr < 8'h50 && paddr[1:0] == 2'b00 && paddr[3:2] != 2'b11);
    assign ctlAddr = paddr < 8'h50 && paddr[3:0] == 4'h0;
    assign ctlMask = (paddr == 8'h00) ? 16'hA076
        : (paddr == 8'h10 || paddr == 8'h30) ? 16'hA07A : 16'hA072;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    chk_ready_access: assert property (pready == (psel && penable))
        else $error("pready differs from access phase");
    chk_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without pslverr");
    chk_err_mapped: assert property (pslverr |-> psel && penable && !mapped)
        else $error("pslverr on mapped access");
    chk_bad_read: assert property (psel && penable && !pwrite && !mapped |-> prdata == 0)
        else $error("unmapped read not zero");
    chk_ctrl_bits: assert property (
        psel && penable && !pwrite && ctlAddr |-> (prdata & ~{16'h0000, ctlMask}) == 0)
        else $error("unimplemented control bit read as one");
    chk_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed without read");
    chk_adc_pulse: assert property (adcTrigger |=> !adcTrigger)
        else $error("adc trigger longer than one cycle");
    chk_irq_masked: assert property (
        psel && penable && pwrite && paddr == 8'h54 && pwdata[4:0] == 5'h00 |=> !irq)
        else $error("irq high with mask clear");
    cover property (adcTrigger);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule

bind timer_set timer_set_props i_timer_set_props (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .adcTrigger(adcTrigger)
);

// [ext_pin_model.sv]
// model of the external clock and gate pins
module ext_pin_model (
    input wire logic refClk,
    input wire logic [2:0] pinSel,
    input wire logic [7:0] edgeNum,
    input wire logic edgeGo,
    input wire logic gateLevel,
    output logic firstPin,
    output logic [3:0] pairPins,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lvl = 1'b0;
    logic pin;
    initial busy = 1'b0;
    // burst of rising edges, pin still between bursts
    always @(posedge refClk) begin
        if (edgeGo && !busy) begin
            busy <= 1'b1;
            for (int k = 0; k < edgeNum; k++) begin
                repeat (3) @(posedge refClk);
                lvl <= 1'b1;
                repeat (3) @(posedge refClk);
                lvl <= 1'b0;
            end
            busy <= 1'b0;
        end
    end
    // gate level held on the selected pin
    assign pin = lvl | gateLevel;
    assign firstPin = (pinSel == 3'd0) & pin;
    assign pairPins = {4{pin}} & (4'b0001 << (pinSel - 3'd1));
endmodule

// [general_purpose_timer_set_bench.sv]
// self-checking bench of the timer set
module general_purpose_timer_set_bench;
    import timer_set_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
        $display("Error %s expected %h seen %h", nm, e, g); end end
    logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, edgeNum = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r;
    logic pready, pslverr, irq, adcTrigger, firstPin, busy, lastErr;
    logic idleMode = 1'b0, edgeGo = 1'b0, gateLevel = 1'b0;
    logic [3:0] pairPins;
    logic [2:0] pinSel = 3'd0;
    int err_total = 0, check_count = 0, seed = 41817, n;
    localparam logic [15:0] MASKS [5] = '{16'hA076, 16'hA07A, 16'hA072, 16'hA07A, 16'hA072};
    localparam int DIVS [4] = '{1, 8, 64, 256};
    timer_set i_timer_set (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .idleMode(idleMode),
        .first_timer_ext_clock_pin(firstPin), .pair_timer_ext_clock_pin(pairPins),
        .irq(irq), .adcTrigger(adcTrigger));
    ext_pin_model i_ext_pin_model (.refClk(ref_clk), .pinSel(pinSel), .edgeNum(edgeNum),
        .edgeGo(edgeGo), .gateLevel(gateLevel), .firstPin(firstPin), .pairPins(pairPins),
        .busy(busy));
    initial forever #10 ref_clk = ~ref_clk;
    // ------------------------------------------------------------
    // apb master and helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && t < 20) begin
            t++;
            @(posedge ref_clk);
        end
        if (t >= 20) err_total++;
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic pulses(input logic [2:0] s, input logic [7:0] k);
        pinSel <= s;
        edgeNum <= k;
        edgeGo <= 1'b1;
        @(posedge ref_clk);
        edgeGo <= 1'b0;
        #1;
        for (int t = 0; t < 200 && busy; t++) @(posedge ref_clk);
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic finish_test();
        if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 16 + 4), 0);
            `CHECK("period", 32'h0000_FFFF, rd)
            apb(1'b0, 8'(i * 16), 0);
            `CHECK("ctrl reset", 32'h0000_0000, rd)
            r = $random(seed) & 32'h0000_7FFF;
            apb(1'b1, 8'(i * 16), r);
            apb(1'b0, 8'(i * 16), 0);
            `CHECK("ctrl bits", r & {16'h0000, MASKS[i]}, rd)
            apb(1'b1, 8'(i * 16), 0);
            for (int c = 0; c < 4; c++) begin
                apb(1'b1, 8'(i * 16 + 8), 0);
                apb(1'b1, 8'(i * 16), 32'h0000_8000 | (c << 4));
                repeat (12 * DIVS[c]) @(posedge ref_clk);
                apb(1'b1, 8'(i * 16), 32'(c << 4));
                apb(1'b0, 8'(i * 16 + 8), 0);
                `CHECK("prescale", 1'b1, rd >= 5 && rd <= 8)
            end
        end
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        `CHECK("unmapped err", 1'b1, lastErr)
        apb(1'b0, 8'h60, 0);
        `CHECK("unmapped data", 32'h0000_0000, rd)
        apb(1'b1, 8'h08, 0);
        apb(1'b1, 8'h00, 32'h0000_8030);
        for (int k = 0; k < 8; k++) begin
            repeat (300) @(posedge ref_clk);
            apb(1'b1, 8'h00, 32'h0000_8030);
        end
        apb(1'b1, 8'h00, 0);
        apb(1'b0, 8'h08, 0);
        `CHECK("prescale clear", 32'h0000_0000, rd)
        idleMode <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, 8'h08, 0);
            apb(1'b1, 8'h00, 32'h0000_8000 | (b << 13));
            repeat (40) @(posedge ref_clk);
            apb(1'b1, 8'h00, 0);
            apb(1'b0, 8'h08, 0);
            `CHECK("idle stop", b[0], rd == 0)
        end
        idleMode <= 1'b0;
        r = 3 + ($random(seed) & 7);
        apb(1'b1, 8'h34, r);
        apb(1'b1, 8'h38, 0);
        apb(1'b1, 8'h30, 32'h0000_8000);
        repeat (60) @(posedge ref_clk);
        apb(1'b0, 8'h50, 0);
        `CHECK("match status", 1'b1, rd[3])
        `CHECK("masked irq", 1'b0, irq)
        apb(1'b0, 8'h38, 0);
        `CHECK("wrap", 1'b1, rd <= r)
        apb(1'b1, 8'h54, 32'h0000_0008);
        `CHECK("irq", 1'b1, irq)
        apb(1'b1, 8'h30, 32'h0000_8040);
        gateLevel <= 1'b1;
        pinSel <= 3'd3;
        repeat (40) @(posedge ref_clk);
        gateLevel <= 1'b0;
        apb(1'b1, 8'h50, 32'h0000_001F);
        repeat (10) @(posedge ref_clk);
        apb(1'b0, 8'h50, 0);
        `CHECK("gate fall", 32'h0000_0008, rd)
        apb(1'b0, 8'h38, 0);
        r = rd;
        apb(1'b0, 8'h38, 0);
        `CHECK("gate hold", r, rd)
        apb(1'b1, 8'h30, 0);
        apb(1'b1, 8'h50, 32'h0000_001F);
        `CHECK("irq clear", 1'b0, irq)
        apb(1'b1, 8'h10, 32'h0000_0008);
        apb(1'b1, 8'h20, 32'h0000_8030);
        apb(1'b1, 8'h14, 32'h0000_0008);
        apb(1'b1, 8'h24, 32'h0000_0001);
        apb(1'b1, 8'h18, 32'h0000_FFFE);
        apb(1'b1, 8'h28, 0);
        apb(1'b1, 8'h54, 32'h0000_0006);
        apb(1'b1, 8'h10, 32'h0000_8008);
        repeat (6) @(posedge ref_clk);
        apb(1'b1, 8'h10, 32'h0000_0008);
        apb(1'b0, 8'h28, 0);
        `CHECK("high word", 32'h0000_0001, rd)
        apb(1'b0, 8'h18, 0);
        `CHECK("low word", 1'b1, rd < 8)
        apb(1'b1, 8'h10, 32'h0000_8008);
        n = 0;
        while (adcTrigger !== 1'b1 && n < 100) begin
            n++;
            @(posedge ref_clk);
        end
        `CHECK("adc trigger", 1'b1, adcTrigger)
        apb(1'b0, 8'h50, 0);
        `CHECK("wide flag", 2'b10, rd[2:1])
        apb(1'b1, 8'h10, 0);
        apb(1'b1, 8'h20, 0);
        apb(1'b1, 8'h54, 0);
        // timers 0 (sync), 2, 4, then timer 0 again unsynchronised
        for (int j = 0; j < 4; j++) begin
            int tm;
            tm = (j == 3) ? 0 : j * 2;
            r = 5 + ($random(seed) & 7);
            apb(1'b1, 8'(tm * 16 + 4), 32'h0000_FFFF);
            apb(1'b1, 8'(tm * 16 + 8), 0);
            apb(1'b1, 8'(tm * 16), j == 0 ? 32'h0000_8006 : 32'h0000_8002);
            pulses(3'(tm), r[7:0]);
            apb(1'b1, 8'(tm * 16), 0);
            apb(1'b0, 8'(tm * 16 + 8), 0);
            `CHECK("ext edges", r, rd)
        end
        finish_test();
    end
endmodule
